// ### dsa_endpoint_model.sv
// Endpoint model: takes read commands, promptly or with random stalls.
// Assumes commands arrive synchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module dsa_endpoint_model (
	// Clock and reset
	input  wire logic clk,
	input  wire logic reset,
	// Command acceptance
	output logic      rdReady,
	// Stall control
	input  wire logic slow
);
	logic [7:0] lfsr;

	// Pseudo-random stalls so the source must hold its command
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			lfsr    <= 8'h5A;
			rdReady <= 1'b0;
		end else begin
			lfsr    <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
			rdReady <= !slow || lfsr[0];
		end
	end
endmodule
`default_nettype wire

// ### dsa_pkg.sv
// Package for the source-side active state of a DMA transfer controller.
// Assumes one clock domain; register offsets are byte addresses on a 32-bit bus.
`default_nettype none
package dsa_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_OPT     = 8'h00;
	localparam logic [7:0] OFS_SRC     = 8'h04;
	localparam logic [7:0] OFS_CNT     = 8'h08;
	localparam logic [7:0] OFS_DST     = 8'h0C;
	localparam logic [7:0] OFS_BIDX    = 8'h10;
	localparam logic [7:0] OFS_PRXY    = 8'h14;
	localparam logic [7:0] OFS_CNTRLD  = 8'h18;
	localparam logic [7:0] OFS_SRCBREF = 8'h1C;
	localparam logic [7:0] OFS_DSTBREF = 8'h20;
	localparam logic [7:0] OFS_STAT    = 8'h24;
	localparam logic [7:0] OFS_MASK    = 8'h28;
	localparam logic [7:0] OFS_DFOPT   = 8'h40;

	// Field positions
	localparam int OPT_CHEN_BIT = 22;
	localparam int OPT_IEN_BIT  = 20;
	localparam int OPT_CODE_LSB = 12;
	localparam int OPT_WIDTH_LSB  = 8;
	localparam int OPT_PRIO_LSB   = 4;
	localparam int OPT_DCON_BIT   = 1;
	localparam int OPT_SCON_BIT   = 0;
	localparam int PRX_LEVEL_BIT  = 8;
	localparam int STAT_DONE    = 0;
	localparam int STAT_CHAIN   = 1;

	// Reset values and widths
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [2:0]  WIDTH_CODE_MAX = 3'h5;
	localparam int          STAT_W   = 2;

	typedef struct packed {
		logic       chainEn;
		logic       irqEn;
		logic [5:0] code;
		logic [2:0] fifoWidth;
		logic [2:0] prio;
		logic       dstConst;
		logic       srcConst;
	} dsa_opt_t;

	typedef struct packed {
		dsa_opt_t    opt;
		logic [31:0] srcAddr;
		logic [15:0] byteCount;
		logic [15:0] arrayCount;
		logic [15:0] srcStride;
		logic        privilege;
		logic [3:0]  requesterId;
	} dsa_req_t;

	typedef struct packed {
		logic [31:0] addr;
		logic [15:0] bytes;
		logic        privilege;
		logic [3:0]  requesterId;
	} dsa_rd_t;

	typedef struct packed {
		logic [5:0] code;
		logic       chain;
		logic       irq;
	} dsa_cpl_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_ISSUE = 2'b01,
		ST_DONE  = 2'b10
	} dsa_state_t;

endpackage
`default_nettype wire

// ### dsa_source_active.sv
// Source-side active state: takes transfer requests, issues read commands,
// reports completion, and exposes its working state over classic Wishbone.
// Assumes the channel controller and endpoints are synchronous to clk.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - Option bit 22 enables chaining; completion then signals chaining.
// - Option bit 20 enables the completion interrupt indication.
// - Six-bit completion code in bits 17:12 goes to the channel controller.
// - FIFO width codes 0-5h mean 8 to 256 bits; 6h-7h reserved.
// - Priority bits 6:4 mirror queue priority; 0 highest, 7h lowest.
// - Destination mode bit 1: clear increments, set holds constant.
// - Source mode bit 0: clear increments, set holds constant within FIFO width.
// - Keep 32-bit working source address, advanced per source mode.
// - Remaining-array count bits 31:16 decrements per array, zero at finish.
// - Remaining-byte count bits 15:0 drops by command bytes, zero at finish.
// - Index register low half is source stride; upper half reads zero.
// - Destination address and destination base registers read zero.
// - Privilege bit 8 captured at submission, sent with every command.
// - Four-bit requester id captured at submission, sent with every command.
// - Keep original byte count and reload it after each array.
// - Keep 32-bit base address of the array being read.
// - One destination option register per destination entry.
// - Destination depth set by DST_DEPTH, four by default; the testbench uses two.
module dsa_source_active #(
	parameter int DST_DEPTH = 4,
	parameter int MAX_BURST = 64
) (
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 reset,
	// Wishbone slave
	input  wire logic                 wbCyc,
	input  wire logic                 wbStb,
	input  wire logic                 wbWe,
	input  wire logic [7:0]           wbAdr,
	input  wire logic [3:0]           wbSel,
	input  wire logic [31:0]          wbDatIn,
	output logic                      wbAck,
	output logic [31:0]               wbDatOut,
	// Request from channel controller
	input  wire logic                 reqValid,
	input  wire dsa_pkg::dsa_req_t    reqData,
	output logic                      reqReady,
	// Read commands to endpoints
	output logic                      rdValid,
	output dsa_pkg::dsa_rd_t          rdCmd,
	input  wire logic                 rdReady,
	// Completion to channel controller
	output logic                      cplValid,
	output dsa_pkg::dsa_cpl_t         cplData,
	// Interrupt
	output logic                      irq
);
	import dsa_pkg::*;

	// Option field placement, shared by the option register and every destination option register
	function automatic logic [31:0] packOpt(input dsa_opt_t o);
		logic [31:0] w;
		w = RST_WORD;
		w[OPT_CHEN_BIT] = o.chainEn;
		w[OPT_IEN_BIT] = o.irqEn;
		w[OPT_CODE_LSB +: 6] = o.code;
		w[OPT_WIDTH_LSB +: 3] = o.fifoWidth;
		w[OPT_PRIO_LSB +: 3] = o.prio;
		w[OPT_DCON_BIT] = o.dstConst;
		w[OPT_SCON_BIT] = o.srcConst;
		return w;
	endfunction

	// FIFO width in bytes; reserved codes fall back to one byte
	function automatic logic [15:0] fifoBytes(input logic [2:0] f);
		fifoBytes = (f > WIDTH_CODE_MAX) ? 16'h0001 : 16'h0001 << f;
	endfunction

	localparam logic [15:0] BURST = 16'(MAX_BURST);
	localparam int PW = (DST_DEPTH > 1) ? $clog2(DST_DEPTH) : 1;

	dsa_state_t  state_r, state_nxt;
	dsa_opt_t    opt_r, opt_nxt;
	logic [31:0] src_r, src_nxt, base_r, base_nxt;
	logic [15:0] bytesLeft_r, bytesLeft_nxt, arraysLeft_r, arraysLeft_nxt;
	logic [15:0] rld_r, rld_nxt, stride_r, stride_nxt;
	logic        level_r, level_nxt;
	logic [3:0]  pid_r, pid_nxt;
	logic        reqReady_r, reqReady_nxt;
	logic        rdValid_r, rdValid_nxt;
	dsa_rd_t     rd_r, rd_nxt;
	logic        cplValid_r, cplValid_nxt;
	dsa_cpl_t    cpl_r, cpl_nxt;
	dsa_opt_t    dfOpt_r [DST_DEPTH];
	dsa_opt_t    dfOpt_nxt [DST_DEPTH];
	logic [PW-1:0] dfPtr_r, dfPtr_nxt;
	logic [15:0] chunk;
	logic        cmdDone, arrEnd;

	// Bytes per command: constant mode moves one FIFO word at a time
	always_comb begin
		if (opt_r.srcConst) begin
			chunk = fifoBytes(opt_r.fifoWidth);
		end else begin
			chunk = BURST;
		end
		if (bytesLeft_r < chunk) begin
			chunk = bytesLeft_r;
		end
	end

	assign cmdDone = rdValid_r && rdReady;
	assign arrEnd = cmdDone && (bytesLeft_r == rd_r.bytes);

	// Transfer sequencing
	always_comb begin
		state_nxt = state_r;
		opt_nxt = opt_r;
		src_nxt = src_r;
		base_nxt = base_r;
		bytesLeft_nxt = bytesLeft_r;
		arraysLeft_nxt = arraysLeft_r;
		rld_nxt = rld_r;
		stride_nxt = stride_r;
		level_nxt = level_r;
		pid_nxt = pid_r;
		reqReady_nxt = reqReady_r;
		rdValid_nxt = rdValid_r;
		rd_nxt = rd_r;
		cplValid_nxt = 1'b0;
		cpl_nxt = cpl_r;
		dfPtr_nxt = dfPtr_r;
		dfOpt_nxt = dfOpt_r;
		case (state_r)
			ST_IDLE: begin
				reqReady_nxt = 1'b1;
				if (reqValid && reqReady_r) begin
					reqReady_nxt = 1'b0;
					opt_nxt = reqData.opt;
					src_nxt = reqData.srcAddr;
					base_nxt = reqData.srcAddr;
					bytesLeft_nxt = reqData.byteCount;
					rld_nxt = reqData.byteCount;
					arraysLeft_nxt = reqData.arrayCount;
					stride_nxt = reqData.srcStride;
					level_nxt = reqData.privilege;
					pid_nxt = reqData.requesterId;
					// Entry keeps the destination mode for the write side
					dfOpt_nxt[dfPtr_r] = reqData.opt;
					dfPtr_nxt = (dfPtr_r == PW'(DST_DEPTH - 1)) ? '0 : dfPtr_r + 1'b1;
					if (reqData.byteCount == 16'h0000 || reqData.arrayCount == 16'h0000) begin
						state_nxt = ST_DONE;
					end else begin
						state_nxt = ST_ISSUE;
					end
				end
			end
			ST_ISSUE: begin
				if (!rdValid_r) begin
					rdValid_nxt = 1'b1;
					rd_nxt = '{addr: src_r, bytes: chunk, privilege: level_r, requesterId: pid_r};
				end else if (cmdDone) begin
					rdValid_nxt = 1'b0;
					bytesLeft_nxt = bytesLeft_r - rd_r.bytes;
					if (!opt_r.srcConst) begin
						src_nxt = src_r + 32'(rd_r.bytes);
					end
					if (arrEnd) begin
						arraysLeft_nxt = arraysLeft_r - 16'h0001;
						if (arraysLeft_r == 16'h0001) begin
							state_nxt = ST_DONE;
						end else begin
							bytesLeft_nxt = rld_r;
							base_nxt = base_r + 32'(stride_r);
							src_nxt = base_r + 32'(stride_r);
						end
					end
				end
			end
			ST_DONE: begin
				// Zero-length requests can arrive here with a count still nonzero; both counts are cleared
				bytesLeft_nxt = 16'h0000;
				arraysLeft_nxt = 16'h0000;
				cplValid_nxt = 1'b1;
				cpl_nxt = '{code: opt_r.code, chain: opt_r.chainEn, irq: opt_r.irqEn};
				state_nxt = ST_IDLE;
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_r <= ST_IDLE;
			opt_r <= '0;
			src_r <= RST_WORD;
			base_r <= RST_WORD;
			bytesLeft_r <= '0;
			arraysLeft_r <= '0;
			rld_r <= '0;
			stride_r <= '0;
			level_r <= 1'b0;
			pid_r <= '0;
			reqReady_r <= 1'b0;
			rdValid_r <= 1'b0;
			rd_r <= '0;
			cplValid_r <= 1'b0;
			cpl_r <= '0;
			dfPtr_r <= '0;
			for (int i = 0; i < DST_DEPTH; i++) begin
				dfOpt_r[i] <= '0;
			end
		end else begin
			state_r <= state_nxt;
			opt_r <= opt_nxt;
			src_r <= src_nxt;
			base_r <= base_nxt;
			bytesLeft_r <= bytesLeft_nxt;
			arraysLeft_r <= arraysLeft_nxt;
			rld_r <= rld_nxt;
			stride_r <= stride_nxt;
			level_r <= level_nxt;
			pid_r <= pid_nxt;
			reqReady_r <= reqReady_nxt;
			rdValid_r <= rdValid_nxt;
			rd_r <= rd_nxt;
			cplValid_r <= cplValid_nxt;
			cpl_r <= cpl_nxt;
			dfPtr_r <= dfPtr_nxt;
			dfOpt_r <= dfOpt_nxt;
		end
	end

	// Register bus, status and mask
	logic              ack_r, ack_nxt, irq_r, irq_nxt;
	logic [31:0]       dat_r, dat_nxt;
	logic [STAT_W-1:0] stat_r, stat_nxt, mask_r, mask_nxt, evt;
	logic              wbReq, wbWr;

	assign wbReq = wbCyc && wbStb && !ack_r;
	assign wbWr = wbReq && wbWe && wbSel[0];

	always_comb begin
		evt = '0;
		evt[STAT_DONE] = cplValid_nxt && cpl_nxt.irq;
		evt[STAT_CHAIN] = cplValid_nxt && cpl_nxt.chain;
		ack_nxt = wbReq;
		dat_nxt = dat_r;
		stat_nxt = stat_r;
		mask_nxt = mask_r;
		// Set wins over a write-one clear in the same cycle
		if (wbWr && wbAdr == OFS_STAT) begin
			stat_nxt = stat_r & ~wbDatIn[STAT_W-1:0];
		end
		stat_nxt = stat_nxt | evt;
		if (wbWr && wbAdr == OFS_MASK) begin
			mask_nxt = wbDatIn[STAT_W-1:0];
		end
		irq_nxt = |(stat_nxt & mask_nxt);
		if (wbReq && !wbWe) begin
			case (wbAdr)
				OFS_OPT:     dat_nxt = packOpt(opt_r);
				OFS_SRC:     dat_nxt = src_r;
				OFS_CNT:     dat_nxt = {arraysLeft_r, bytesLeft_r};
				OFS_DST:     dat_nxt = RST_WORD;
				OFS_BIDX:    dat_nxt = {16'h0000, stride_r};
				OFS_PRXY:    dat_nxt = 32'({level_r, 4'h0, pid_r});
				OFS_CNTRLD:  dat_nxt = {16'h0000, rld_r};
				OFS_SRCBREF: dat_nxt = base_r;
				OFS_DSTBREF: dat_nxt = RST_WORD;
				OFS_STAT:    dat_nxt = 32'(stat_r);
				OFS_MASK:    dat_nxt = 32'(mask_r);
				default: begin
					dat_nxt = RST_WORD;
					for (int i = 0; i < DST_DEPTH; i++) begin
						if (wbAdr == OFS_DFOPT + 8'(4 * i)) begin
							dat_nxt = packOpt(dfOpt_r[i]);
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ack_r <= 1'b0;
			dat_r <= RST_WORD;
			stat_r <= '0;
			mask_r <= '0;
			irq_r <= 1'b0;
		end else begin
			ack_r <= ack_nxt;
			dat_r <= dat_nxt;
			stat_r <= stat_nxt;
			mask_r <= mask_nxt;
			irq_r <= irq_nxt;
		end
	end

	// Outputs straight from flip-flops
	assign wbAck = ack_r;
	assign wbDatOut = dat_r;
	assign reqReady = reqReady_r;
	assign rdValid = rdValid_r;
	assign rdCmd = rd_r;
	assign cplValid = cplValid_r;
	assign cplData = cpl_r;
	assign irq = irq_r;

	// Checks on the working state
	sequence sMidCmd;
		cmdDone && !arrEnd;
	endsequence

	sequence sNextArr;
		arrEnd && arraysLeft_r != 16'h0001;
	endsequence

	AST_CHAIN: assert property (@(posedge clk) disable iff (reset)
		cplValid_r |-> cpl_r.chain == opt_r.chainEn && (!opt_r.chainEn || stat_r[STAT_CHAIN]))
		else $error("chain flag does not follow option");

	AST_IRQ: assert property (@(posedge clk) disable iff (reset)
		cplValid_r && opt_r.irqEn && mask_r[STAT_DONE] |-> irq)
		else $error("completion interrupt missing");

	AST_CODE: assert property (@(posedge clk) disable iff (reset)
		cplValid_r |-> cpl_r.code == opt_r.code)
		else $error("completion code mismatch");

	AST_PRIVILEGE_LEVEL: assert property (@(posedge clk) disable iff (reset)
		rdValid_r |-> rd_r.privilege == level_r && rd_r.requesterId == pid_r)
		else $error("privilege not carried on command");

	AST_ADVANCE: assert property (@(posedge clk) disable iff (reset)
		sMidCmd and !opt_r.srcConst |=> src_r == $past(src_r) + 32'($past(rd_r.bytes)))
		else $error("source address did not increment");

	AST_CONST: assert property (@(posedge clk) disable iff (reset)
		sMidCmd and opt_r.srcConst |=> $stable(src_r) && bytesLeft_r == $past(bytesLeft_r) - $past(rd_r.bytes))
		else $error("constant mode address moved");

	AST_RELOAD: assert property (@(posedge clk) disable iff (reset)
		sNextArr |=> bytesLeft_r == rld_r && src_r == base_r && base_r == $past(base_r) + 32'($past(stride_r))
			&& arraysLeft_r == $past(arraysLeft_r) - 16'h0001)
		else $error("array reload wrong");

	AST_FINISH: assert property (@(posedge clk) disable iff (reset)
		arrEnd && arraysLeft_r == 16'h0001 |=> bytesLeft_r == 16'h0000 && arraysLeft_r == 16'h0000 ##1 cplValid_r)
		else $error("finish did not zero counts or complete");

	AST_DSTZERO: assert property (@(posedge clk) disable iff (reset)
		wbReq && !wbWe && (wbAdr == OFS_DST || wbAdr == OFS_DSTBREF) |=> wbAck && wbDatOut == RST_WORD)
		else $error("destination register not zero");

	AST_BURST: assert property (@(posedge clk) disable iff (reset)
		rdValid_r && opt_r.srcConst |-> rd_r.bytes <= fifoBytes(opt_r.fifoWidth))
		else $error("constant mode command exceeds FIFO width");

endmodule
`default_nettype wire

// ### dsa_source_active_tb.sv
// Testbench: random requests against a queue model, register readback, interrupt.
// Assumes one clock; the endpoint model answers read commands.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checksDone++; if ((g) !== (e)) begin mismatches++; \
	$display("ERROR %0t: got %h expected %h", $time, g, e); end end
module dsa_source_active_tb;
	import dsa_pkg::*;
	localparam int DEPTH = 2;
	localparam int BURST = 64;
	logic        clk, reset, wbCyc, wbStb, wbWe, wbAck, reqValid, reqReady;
	logic        rdValid, rdReady, cplValid, irq, slow;
	logic [7:0]  wbAdr;
	logic [3:0]  wbSel;
	logic [31:0] wbDatIn, wbDatOut, rng, rdw, w, srcExp, baseExp;
	logic [1:0]  statExp, maskVal;
	dsa_req_t    reqData, r;
	dsa_rd_t     rdCmd, rdExp;
	dsa_cpl_t    cplData, cplExp;
	dsa_rd_t     expQ[$];
	dsa_cpl_t    cplQ[$];
	int          mismatches, checksDone, cplSeen, i;

	dsa_source_active #(.DST_DEPTH(DEPTH), .MAX_BURST(BURST)) dut (.clk(clk), .reset(reset),
		.wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatIn(wbDatIn),
		.wbAck(wbAck), .wbDatOut(wbDatOut), .reqValid(reqValid), .reqData(reqData), .reqReady(reqReady),
		.rdValid(rdValid), .rdCmd(rdCmd), .rdReady(rdReady), .cplValid(cplValid), .cplData(cplData), .irq(irq));
	dsa_endpoint_model partner (.clk(clk), .reset(reset), .rdReady(rdReady), .slow(slow));

	// Clock, 4 ns period
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	function automatic logic [31:0] nextRand();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction

	function automatic logic [31:0] optWord(dsa_opt_t o);
		return {9'h0, o.chainEn, 1'b0, o.irqEn, 2'h0, o.code, 1'b0, o.fifoWidth, 1'b0, o.prio, 2'h0, o.dstConst,
			o.srcConst};
	endfunction

	task automatic give_verdict();
		if (mismatches == 0 && checksDone > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// One classic cycle; held until ack is sampled
	task automatic wbXfer(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		wbCyc   <= 1'b1;
		wbStb   <= 1'b1;
		wbWe    <= we;
		wbSel   <= 4'hF;
		wbAdr   <= a;
		wbDatIn <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wbAck !== 1'b1 && n < 20);
		rdw = wbDatOut;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		if (n >= 20) begin
			mismatches++;
			give_verdict();
		end
	endtask

	task automatic chkReg(input logic [7:0] a, input logic [31:0] e);
		wbXfer(1'b0, a, 32'h0000_0000);
		`CHK(rdw, e)
	endtask

	// Model the command stream, submit, wait for completion
	task automatic runReq(input dsa_req_t q);
		int a, b, by, fw, n, k;
		logic [31:0] base, adr;
		fw = (q.opt.fifoWidth <= WIDTH_CODE_MAX) ? (1 << q.opt.fifoWidth) : 1;
		base = q.srcAddr;
		srcExp = q.srcAddr;
		baseExp = q.srcAddr;
		for (b = 0; b < q.arrayCount && q.byteCount != 0; b++) begin
			adr = base;
			baseExp = base;
			a = q.byteCount;
			while (a > 0) begin
				by = q.opt.srcConst ? (a < fw ? a : fw) : (a < BURST ? a : BURST);
				expQ.push_back(dsa_rd_t'{adr, by[15:0], q.privilege, q.requesterId});
				if (!q.opt.srcConst) adr += by;
				a -= by;
			end
			// Last array leaves the address just past its final command in increment mode, at its base in constant mode
			srcExp = adr;
			base += {16'h0, q.srcStride};
		end
		cplQ.push_back(dsa_cpl_t'{q.opt.code, q.opt.chainEn, q.opt.irqEn});
		n = cplSeen;
		@(posedge clk);
		reqValid <= 1'b1;
		reqData  <= q;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (reqReady !== 1'b1 && k < 100);
		reqValid <= 1'b0;
		if (reqReady !== 1'b1) begin
			mismatches++;
			give_verdict();
		end
		for (k = 0; cplSeen == n && k < 5000; k++) @(posedge clk);
		if (cplSeen == n) begin
			mismatches++;
			give_verdict();
		end
		`CHK(expQ.size(), 0)
		statExp |= {q.opt.chainEn, q.opt.irqEn};
	endtask

	// Every accepted read command against the model
	always @(posedge clk) begin
		if (rdValid === 1'b1 && rdReady === 1'b1) begin
			if (expQ.size() == 0) begin
				mismatches++;
				$display("ERROR %0t: unexpected read command", $time);
			end else begin
				// Pop once; the compare macro names its expected value twice
				rdExp = expQ.pop_front();
				`CHK(rdCmd, rdExp)
			end
		end
	end

	// Completion pulses against the model
	always @(posedge clk) begin
		if (cplValid === 1'b1) begin
			cplSeen++;
			cplExp = cplQ.pop_front();
			`CHK(cplData, cplExp)
		end
	end

	initial begin
		rng = 32'h0000_0044;
		reset = 1'b1;
		{wbCyc, wbStb, wbWe, reqValid, slow} = 5'h00;
		wbAdr = 8'h00;
		wbSel = 4'hF;
		wbDatIn = 32'h0000_0000;
		reqData = '0;
		{mismatches, checksDone, cplSeen} = '0;
		statExp = 2'h0;
		maskVal = 2'h1;
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		wbXfer(1'b1, OFS_MASK, {30'h0, maskVal});
		// Const mode sweeps every width code, then increment mode, then empty
		for (i = 0; i < 10; i++) begin
			w = nextRand();
			r.opt = dsa_opt_t'{w[0], w[1], w[7:2], i[2:0], w[10:8], w[11], i < 8};
			r.srcAddr = nextRand();
			r.byteCount = (i == 9) ? 16'h0000 : 16'(1 + w[31:16] % 150);
			r.arrayCount = 16'(1 + w[13:12] % 3);
			r.srcStride = {1'b0, w[30:16]};
			r.privilege = w[14];
			r.requesterId = w[18:15];
			slow <= i[1];
			if (i == 5) begin
				maskVal = 2'h3;
				wbXfer(1'b1, OFS_MASK, {30'h0, maskVal});
			end
			runReq(r);
			chkReg(OFS_OPT, optWord(r.opt));
			chkReg(OFS_SRC, srcExp);
			chkReg(OFS_SRCBREF, baseExp);
			chkReg(OFS_CNT, 32'h0000_0000);
			chkReg(OFS_BIDX, {16'h0, r.srcStride});
			chkReg(OFS_PRXY, {23'h0, r.privilege, 4'h0, r.requesterId});
			chkReg(OFS_CNTRLD, {16'h0, r.byteCount});
			chkReg(OFS_DST, 32'h0000_0000);
			chkReg(OFS_DSTBREF, 32'h0000_0000);
			chkReg(OFS_DFOPT + 8'(4 * (i % DEPTH)), optWord(r.opt));
			chkReg(8'h3C, 32'h0000_0000);
			chkReg(OFS_STAT, {30'h0, statExp});
			`CHK(irq, |(statExp & maskVal))
			wbXfer(1'b1, OFS_STAT, 32'h0000_0003);
			statExp = 2'h0;
			@(posedge clk);
			`CHK(irq, 1'b0)
		end
		give_verdict();
	end
endmodule
`default_nettype wire
